// ==== src/acr_params.svh ====
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// register addresses
`define ACR_ADDR_RESET_RB      8'h00
`define ACR_ADDR_LOW_RATE      8'h20
`define ACR_ADDR_REF_STBY      8'h3F
`define ACR_ADDR_POWER         8'h40
`define ACR_ADDR_IFACE         8'h41
`define ACR_ADDR_CLK_EDGE      8'h44
`define ACR_ADDR_A_TEST        8'h62
`define ACR_ADDR_A_PED         8'h63
`define ACR_ADDR_B_OFS_EN      8'h66
`define ACR_ADDR_B_GAIN        8'h68
`define ACR_ADDR_B_FINE        8'h6A
`define ACR_ADDR_B_TEST        8'h75
`define ACR_ADDR_B_PED         8'h76

// field positions
`define ACR_BIT_SOFT_RESET     7
`define ACR_BIT_READBACK       0
`define ACR_BIT_LOW_RATE       2
`define ACR_REF_HI             6
`define ACR_REF_LO             5
`define ACR_BIT_STANDBY        1
`define ACR_PWR_HI             3
`define ACR_PWR_LO             0
`define ACR_BIT_DDR            7
`define ACR_RISE_HI            7
`define ACR_RISE_LO            5
`define ACR_FALL_HI            4
`define ACR_FALL_LO            2
`define ACR_TEST_HI            2
`define ACR_TEST_LO            0
`define ACR_PED_HI             5
`define ACR_PED_LO             0
`define ACR_BIT_OFS_EN         6
`define ACR_GAIN_HI            7
`define ACR_GAIN_LO            4
`define ACR_TC_HI              3
`define ACR_TC_LO              0
`define ACR_FINE_HI            6
`define ACR_FINE_LO            0

// reset values and codes
`define ACR_REG_RST            8'h00
`define ACR_REF_EXTERNAL       2'h3
`define ACR_PWR_PIN_PREFIX     1'h1

// serial frame: 8 address bits then 8 data bits
`define ACR_ADDR_BITS          8
`define ACR_FRAME_BITS         16

`endif

// ==== src/acr_pkg.sv ====
package acr_pkg;

  typedef enum logic [3:0] {
    ACR_PWR_PINS      = 4'b0000,
    ACR_PWR_NORMAL    = 4'b1000,
    ACR_PWR_BUF_OFF_B = 4'b1001,
    ACR_PWR_BUF_OFF_A = 4'b1010,
    ACR_PWR_BUF_OFF   = 4'b1011,
    ACR_PWR_GLOBAL_PD = 4'b1100,
    ACR_PWR_STBY_B    = 4'b1101,
    ACR_PWR_STBY_A    = 4'b1110,
    ACR_PWR_INTERLEAV = 4'b1111
  } acr_pwr_mode_t;

  // edge placement: signed shift in 26ths of a sample period
  typedef struct packed {
    logic             align_data;
    logic signed [3:0] shift_26th;
  } acr_edge_t;

  typedef struct packed {
    logic [7:0] reset_rb;
    logic [7:0] low_rate;
    logic [7:0] ref_stby;
    logic [7:0] power;
    logic [7:0] iface;
    logic [7:0] clk_edge;
    logic [7:0] a_test;
    logic [7:0] a_ped;
    logic [7:0] b_ofs_en;
    logic [7:0] b_gain;
    logic [7:0] b_fine;
    logic [7:0] b_test;
    logic [7:0] b_ped;
  } acr_regs_t;

  typedef struct packed {
    logic       low_rate_mode;
    logic       ref_external;
    logic       ref_powered;
    logic       chan_a_standby;
    logic       chan_b_standby;
    logic       global_power_down;
    logic       chan_a_buf_off;
    logic       chan_b_buf_off;
    logic       channel_interleave_mode;
    logic       ddr_output;
    acr_edge_t  rise_edge;
    acr_edge_t  fall_edge;
    logic [2:0] chan_a_test_pattern;
    logic [5:0] chan_a_pedestal;
    logic       chan_b_offset_corr_en;
    logic [3:0] chan_b_coarse_gain;
    logic [3:0] chan_b_time_const;
    logic [6:0] chan_b_fine_gain;
    logic [2:0] chan_b_test_pattern;
    logic [5:0] chan_b_pedestal;
  } acr_ctrl_t;

endpackage

// ==== src/acr_config_regs.sv ====
//
// Contract
// - writing 1 to address 00 bit 7 resets all registers; bit reads back 0
// - readback disabled: readback pin actively driven low, never released
// - readback enabled: readback pin shifts out addressed register contents
// - reference field 01 selects internal, 11 selects external reference
// - standby bit puts both channels in standby; clearing restores operation
// - in standby, references and output buffers stay powered
// - power mode 0000 takes power state from the three power pins
// - 1000 normal; 1001/1010/1011 disable buffers of B, A, both
// - 1100 global power down; 1101 B standby; 1110 A standby
// - 1111 interleaves both channels on A outputs, single-ended only
// - interface bit 7: 0 single-ended parallel, 1 double-data-rate differential
// - differential rising edge: 000/100 default, 101 +4/26, 110 aligned, 111 -4/26
// - differential falling edge: 000/100 default, 101 +4/26, 110 -6/26, 111 -4/26
// - single-ended rising edge: 000/100 default, 101 +4/26, 110 -6/26, 111 -4/26
// - single-ended falling edge: 000/100 default, 101 +4/26, 110 -6/26
// - single-ended falling edge code 111 shifts by -4/26
// - one write updates every field of that register together
//
`timescale 1ns/10ps
`include "acr_params.svh"

module acr_config_regs (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              reset_pulse,
  input  wire logic              ser_enable_n,
  input  wire logic              ser_clk,
  input  wire logic              ser_data,
  input  wire logic              power_pin_one,
  input  wire logic              power_pin_two,
  input  wire logic              power_pin_three,
  output logic                   readback_serial_pin_o,
  output logic                   readback_serial_pin_oe_n,
  output acr_pkg::acr_ctrl_t     ctrl
);

  // edge decode shared by rising and falling edge fields
  function automatic acr_pkg::acr_edge_t edge_decode(input logic [2:0] code,
                                                      input logic       ddr,
                                                      input logic       is_rise);
    acr_pkg::acr_edge_t e;
    e.align_data = 1'b0;
    e.shift_26th = 4'sh0;
    unique case (code)
      3'h5: e.shift_26th = 4'sh4;
      3'h6:
      begin
        if (ddr && is_rise)
          e.align_data = 1'b1;
        else
          e.shift_26th = -4'sh6;
      end
      3'h7: e.shift_26th = -4'sh4;
      default: e.shift_26th = 4'sh0;                          // 000, 100 and spare codes stay default
    endcase
    return e;
  endfunction

  // serial shifter state
  logic [4:0]           bit_cnt;
  logic [4:0]           next_bit_cnt;
  logic [15:0]          shift_in;
  logic [15:0]          next_shift_in;
  logic [7:0]           shift_out;
  logic [7:0]           next_shift_out;
  logic                 sclk_prev;
  logic                 next_sclk_prev;
  logic                 sclk_rise;
  logic                 sclk_fall;
  logic                 frame_done;
  logic [7:0]           wr_addr;
  logic [7:0]           wr_data;

  // register bank state
  acr_pkg::acr_regs_t   regs;
  acr_pkg::acr_regs_t   next_regs;

  // output state
  acr_pkg::acr_ctrl_t   next_ctrl;
  logic                 next_rb_o;

  assign sclk_rise  = ser_clk && !sclk_prev;
  assign sclk_fall  = !ser_clk && sclk_prev;
  assign frame_done = sclk_rise && !ser_enable_n && (bit_cnt == 5'(`ACR_FRAME_BITS - 1));
  assign wr_addr    = shift_in[14:7];
  assign wr_data    = {shift_in[6:0], ser_data};

  // read mux for readback, address is the 8 bits already shifted in
  function automatic logic [7:0] read_mux(input acr_pkg::acr_regs_t r, input logic [7:0] a);
    logic [7:0] d;
    d = `ACR_REG_RST;
    unique case (a)
      `ACR_ADDR_RESET_RB: d = r.reset_rb;
      `ACR_ADDR_LOW_RATE: d = r.low_rate;
      `ACR_ADDR_REF_STBY: d = r.ref_stby;
      `ACR_ADDR_POWER:    d = r.power;
      `ACR_ADDR_IFACE:    d = r.iface;
      `ACR_ADDR_CLK_EDGE: d = r.clk_edge;
      `ACR_ADDR_A_TEST:   d = r.a_test;
      `ACR_ADDR_A_PED:    d = r.a_ped;
      `ACR_ADDR_B_OFS_EN: d = r.b_ofs_en;
      `ACR_ADDR_B_GAIN:   d = r.b_gain;
      `ACR_ADDR_B_FINE:   d = r.b_fine;
      `ACR_ADDR_B_TEST:   d = r.b_test;
      `ACR_ADDR_B_PED:    d = r.b_ped;
      default:            d = `ACR_REG_RST;               // unmapped reads as zero
    endcase
    return d;
  endfunction

  // serial framing and readback shifting
  always_comb
  begin
    next_sclk_prev = ser_clk;
    next_bit_cnt   = bit_cnt;
    next_shift_in  = shift_in;
    next_shift_out = shift_out;
    if (ser_enable_n)
    begin
      // deselect aborts a partial frame with no write
      next_bit_cnt = 5'h00;
    end
    else if (sclk_rise)
    begin
      next_shift_in = {shift_in[14:0], ser_data};
      next_bit_cnt  = frame_done ? 5'h00 : bit_cnt + 5'h01;
      if (bit_cnt == 5'(`ACR_ADDR_BITS - 1))
        next_shift_out = read_mux(regs, {shift_in[6:0], ser_data});
    end
    else if (sclk_fall && (bit_cnt > 5'(`ACR_ADDR_BITS)))
    begin
      next_shift_out = {shift_out[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclk_prev <= 1'b0;
      bit_cnt   <= 5'h00;
      shift_in  <= 16'h0000;
      shift_out <= 8'h00;
    end
    else
    begin
      sclk_prev <= next_sclk_prev;
      bit_cnt   <= next_bit_cnt;
      shift_in  <= next_shift_in;
      shift_out <= next_shift_out;
    end
  end

  // register writes; whole byte lands in one cycle
  always_comb
  begin
    next_regs = regs;
    if (reset_pulse)
    begin
      next_regs = '0;
    end
    else if (frame_done)
    begin
      unique case (wr_addr)
        `ACR_ADDR_RESET_RB:
        begin
          if (wr_data[`ACR_BIT_SOFT_RESET])
            next_regs = '0;
          else
            next_regs.reset_rb = {7'h00, wr_data[`ACR_BIT_READBACK]};
        end
        `ACR_ADDR_LOW_RATE: next_regs.low_rate = {5'h00, wr_data[`ACR_BIT_LOW_RATE], 2'h0};
        `ACR_ADDR_REF_STBY:
          next_regs.ref_stby = {1'b0, wr_data[`ACR_REF_HI:`ACR_REF_LO], 3'h0,
                                wr_data[`ACR_BIT_STANDBY], 1'b0};
        `ACR_ADDR_POWER:    next_regs.power    = {4'h0, wr_data[`ACR_PWR_HI:`ACR_PWR_LO]};
        `ACR_ADDR_IFACE:    next_regs.iface    = {wr_data[`ACR_BIT_DDR], 7'h00};
        `ACR_ADDR_CLK_EDGE: next_regs.clk_edge = {wr_data[7:2], 2'h0};
        `ACR_ADDR_A_TEST:   next_regs.a_test   = {5'h00, wr_data[`ACR_TEST_HI:`ACR_TEST_LO]};
        `ACR_ADDR_A_PED:    next_regs.a_ped    = {2'h0, wr_data[`ACR_PED_HI:`ACR_PED_LO]};
        `ACR_ADDR_B_OFS_EN: next_regs.b_ofs_en = {1'b0, wr_data[`ACR_BIT_OFS_EN], 6'h00};
        `ACR_ADDR_B_GAIN:   next_regs.b_gain   = wr_data;
        `ACR_ADDR_B_FINE:   next_regs.b_fine   = {1'b0, wr_data[`ACR_FINE_HI:`ACR_FINE_LO]};
        `ACR_ADDR_B_TEST:   next_regs.b_test   = {5'h00, wr_data[`ACR_TEST_HI:`ACR_TEST_LO]};
        `ACR_ADDR_B_PED:    next_regs.b_ped    = {2'h0, wr_data[`ACR_PED_HI:`ACR_PED_LO]};
        default:            next_regs = regs;                    // unmapped writes dropped
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      regs <= '0;
    else
      regs <= next_regs;
  end

  // control decode, registered so every output is a flop
  always_comb
  begin
    logic [3:0] pmode;
    logic       ddr;
    pmode = regs.power[`ACR_PWR_HI:`ACR_PWR_LO];
    ddr   = regs.iface[`ACR_BIT_DDR];
    // pin-driven mode reuses the register codes with the top bit forced
    if (pmode == acr_pkg::ACR_PWR_PINS)
      pmode = {`ACR_PWR_PIN_PREFIX, power_pin_one, power_pin_two, power_pin_three};
    next_ctrl = '0;
    next_ctrl.low_rate_mode = regs.low_rate[`ACR_BIT_LOW_RATE];
    next_ctrl.ref_external  =
      (regs.ref_stby[`ACR_REF_HI:`ACR_REF_LO] == `ACR_REF_EXTERNAL);
    next_ctrl.ddr_output    = ddr;
    next_ctrl.chan_a_standby = regs.ref_stby[`ACR_BIT_STANDBY];
    next_ctrl.chan_b_standby = regs.ref_stby[`ACR_BIT_STANDBY];
    unique case (pmode)
      acr_pkg::ACR_PWR_BUF_OFF_B: next_ctrl.chan_b_buf_off = 1'b1;
      acr_pkg::ACR_PWR_BUF_OFF_A: next_ctrl.chan_a_buf_off = 1'b1;
      acr_pkg::ACR_PWR_BUF_OFF:
      begin
        next_ctrl.chan_a_buf_off = 1'b1;
        next_ctrl.chan_b_buf_off = 1'b1;
      end
      acr_pkg::ACR_PWR_GLOBAL_PD: next_ctrl.global_power_down = 1'b1;
      acr_pkg::ACR_PWR_STBY_B:    next_ctrl.chan_b_standby = 1'b1;
      acr_pkg::ACR_PWR_STBY_A:    next_ctrl.chan_a_standby = 1'b1;
      // interleave has no meaning on the differential bus, so it is gated off there
      acr_pkg::ACR_PWR_INTERLEAV: next_ctrl.channel_interleave_mode = !ddr;
      default:                    next_ctrl.global_power_down = 1'b0;  // normal operation
    endcase
    // standby keeps references and buffers up for a quick wake
    next_ctrl.ref_powered = !next_ctrl.global_power_down;
    if (next_ctrl.global_power_down)
    begin
      next_ctrl.chan_a_buf_off = 1'b1;
      next_ctrl.chan_b_buf_off = 1'b1;
    end
    next_ctrl.rise_edge = edge_decode(regs.clk_edge[`ACR_RISE_HI:`ACR_RISE_LO], ddr, 1'b1);
    next_ctrl.fall_edge = edge_decode(regs.clk_edge[`ACR_FALL_HI:`ACR_FALL_LO], ddr, 1'b0);
    next_ctrl.chan_a_test_pattern   = regs.a_test[`ACR_TEST_HI:`ACR_TEST_LO];
    next_ctrl.chan_a_pedestal       = regs.a_ped[`ACR_PED_HI:`ACR_PED_LO];
    next_ctrl.chan_b_offset_corr_en = regs.b_ofs_en[`ACR_BIT_OFS_EN];
    next_ctrl.chan_b_coarse_gain    = regs.b_gain[`ACR_GAIN_HI:`ACR_GAIN_LO];
    next_ctrl.chan_b_time_const     = regs.b_gain[`ACR_TC_HI:`ACR_TC_LO];
    next_ctrl.chan_b_fine_gain      = regs.b_fine[`ACR_FINE_HI:`ACR_FINE_LO];
    next_ctrl.chan_b_test_pattern   = regs.b_test[`ACR_TEST_HI:`ACR_TEST_LO];
    next_ctrl.chan_b_pedestal       = regs.b_ped[`ACR_PED_HI:`ACR_PED_LO];
  end

  // readback pin: always driven, low unless readback is on
  always_comb
  begin
    next_rb_o = 1'b0;
    if (regs.reset_rb[`ACR_BIT_READBACK] && !ser_enable_n &&
        (bit_cnt >= 5'(`ACR_ADDR_BITS)))
      next_rb_o = shift_out[7];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl                     <= '0;
      readback_serial_pin_o    <= 1'b0;
      readback_serial_pin_oe_n <= 1'b0;
    end
    else
    begin
      ctrl                     <= next_ctrl;
      readback_serial_pin_o    <= next_rb_o;
      readback_serial_pin_oe_n <= 1'b0;
    end
  end

endmodule // acr_config_regs

// ==== dv/acr_config_regs_props.sv ====
`timescale 1ns/10ps
module acr_config_regs_props (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               reset_pulse,
  input wire logic               ser_enable_n,
  input wire logic               ser_clk,
  input wire logic               ser_data,
  input wire logic               power_pin_one,
  input wire logic               power_pin_two,
  input wire logic               power_pin_three,
  input wire logic               readback_serial_pin_o,
  input wire logic               readback_serial_pin_oe_n,
  input wire acr_pkg::acr_ctrl_t ctrl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // deselected: no frame can finish inside the two-cycle window
  sequence s_pin_reset;
    reset_pulse && ser_enable_n;
  endsequence
  sequence s_cleared;
    !ctrl.ddr_output && !ctrl.low_rate_mode && !ctrl.ref_external && ctrl.chan_b_coarse_gain == 4'h0;
  endsequence
  a_pin_clears_ctrl: assert property (s_pin_reset |-> ##2 s_cleared)
    else $error("ctrl not cleared after reset pin");
  a_oe_always_on: assert property (readback_serial_pin_oe_n == 1'b0)
    else $error("readback pin released");
  a_idle_pin_low: assert property (ser_enable_n && $past(ser_enable_n) |-> !readback_serial_pin_o)
    else $error("readback pin high while deselected");
  a_standby_powered: assert property (ctrl.chan_a_standby && ctrl.chan_b_standby
    && !ctrl.global_power_down |-> ctrl.ref_powered)
    else $error("references off in standby");
  a_global_pd: assert property (ctrl.global_power_down |->
    ctrl.chan_a_buf_off && ctrl.chan_b_buf_off && !ctrl.ref_powered)
    else $error("global power down incomplete");
  a_no_mux_ddr: assert property (ctrl.ddr_output |-> !ctrl.channel_interleave_mode)
    else $error("interleave with differential output");
  a_rise_codes: assert property (ctrl.rise_edge.shift_26th inside {4'h0, 4'h4, 4'hA, 4'hC})
    else $error("rising edge shift out of set");
  a_rise_align: assert property (ctrl.rise_edge.align_data |->
    ctrl.ddr_output && ctrl.rise_edge.shift_26th == 4'h0)
    else $error("edge alignment outside differential mode");
  a_fall_codes: assert property (!ctrl.fall_edge.align_data
    && ctrl.fall_edge.shift_26th inside {4'h0, 4'h4, 4'hA, 4'hC})
    else $error("falling edge placement out of set");
endmodule // acr_config_regs_props

bind acr_config_regs acr_config_regs_props u_props (
  .clk(clk), .sys_rst(sys_rst), .reset_pulse(reset_pulse), .ser_enable_n(ser_enable_n),
  .ser_clk(ser_clk), .ser_data(ser_data), .power_pin_one(power_pin_one),
  .power_pin_two(power_pin_two), .power_pin_three(power_pin_three),
  .readback_serial_pin_o(readback_serial_pin_o),
  .readback_serial_pin_oe_n(readback_serial_pin_oe_n), .ctrl(ctrl));

// ==== dv/acr_host_model.sv ====
`timescale 1ns/10ps
module acr_host_model (
  input  wire logic clk,
  input  wire logic readback_serial_pin_o,
  output logic      ser_enable_n,
  output logic      ser_clk,
  output logic      ser_data
);
  initial
  begin
    ser_enable_n = 1'b1;
    ser_clk      = 1'b0;
    ser_data     = 1'b0;
  end
  // whole register in one frame, msb first; three low cycles cover readback lag
  task automatic frame(input logic [7:0] addr, input logic [7:0] data, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {addr, data};
    rd = 8'h00;
    @(posedge clk);
    ser_enable_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      ser_data <= sh[i];
      repeat (3) @(posedge clk);
      if (i < 8)
        rd = {rd[6:0], readback_serial_pin_o};
      ser_clk <= 1'b1;
      repeat (2) @(posedge clk);
      ser_clk <= 1'b0;
    end
    @(posedge clk);
    ser_enable_n <= 1'b1;
    ser_data     <= ~ser_data; // no stale data left on the line
    @(posedge clk);
  endtask
endmodule // acr_host_model

// ==== dv/acr_config_regs_bench.sv ====
`timescale 1ns/10ps
module acr_config_regs_bench;
  logic               clk;
  logic               sys_rst;
  logic               reset_pulse;
  logic               power_pin_one;
  logic               power_pin_two;
  logic               power_pin_three;
  logic               ser_enable_n;
  logic               ser_clk;
  logic               ser_data;
  logic               rb_pin;
  logic               rb_oe_n;
  acr_pkg::acr_ctrl_t ctrl;
  logic [7:0]         rd;
  int                 n_errors = 0;
  int                 checks_done = 0;
  logic [7:0] addrs[13] = '{8'h20, 8'h3F, 8'h40, 8'h41, 8'h44, 8'h62, 8'h63, 8'h66, 8'h68,
                            8'h6A, 8'h75, 8'h76, 8'h21};
  logic [7:0] masks[13] = '{8'h04, 8'h62, 8'h0F, 8'h80, 8'hFC, 8'h07, 8'h3F, 8'h40, 8'hFF,
                            8'h7F, 8'h07, 8'h3F, 8'h00};
  logic [7:0] pexp[8]   = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h38, 8'h02, 8'h04, 8'h01};

  acr_config_regs u_dut (.clk(clk), .sys_rst(sys_rst), .reset_pulse(reset_pulse),
    .ser_enable_n(ser_enable_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .power_pin_one(power_pin_one), .power_pin_two(power_pin_two),
    .power_pin_three(power_pin_three), .readback_serial_pin_o(rb_pin),
    .readback_serial_pin_oe_n(rb_oe_n), .ctrl(ctrl));
  acr_host_model u_host (.clk(clk), .readback_serial_pin_o(rb_pin),
    .ser_enable_n(ser_enable_n), .ser_clk(ser_clk), .ser_data(ser_data));

  always #25 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.frame(a, d, rd);
  endtask
  task automatic pwr_bits(output logic [7:0] v);
    v = {2'h0, ctrl.global_power_down, ctrl.chan_a_buf_off, ctrl.chan_b_buf_off,
         ctrl.chan_a_standby, ctrl.chan_b_standby, ctrl.channel_interleave_mode};
  endtask
  task automatic test_done();
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // reset values, reserved bits dropped, unmapped address reads zero
  task automatic t_map();
    chk({7'h0, ctrl.ref_powered}, 8'h01);
    chk({7'h0, rb_oe_n}, 8'h00);
    wr(8'h00, 8'h01);
    for (int i = 0; i < 13; i++)
    begin
      u_host.frame(addrs[i], 8'h00, rd);
      chk(rd, 8'h00);
      wr(addrs[i], 8'hFF);
      u_host.frame(addrs[i], masks[i], rd);
      chk(rd, masks[i]);
    end
    u_host.frame(8'h00, 8'h01, rd);
    chk(rd, 8'h01);
  endtask
  task automatic t_soft_reset();
    wr(8'h68, 8'hA5);
    chk({4'h0, ctrl.chan_b_coarse_gain}, 8'h0A);
    wr(8'h00, 8'h80);
    u_host.frame(8'h00, 8'h01, rd);
    chk(rd, 8'h00);
    u_host.frame(8'h68, 8'h00, rd);
    chk(rd, 8'h00);
    u_host.frame(8'h00, 8'h01, rd);
    chk(rd, 8'h01);
  endtask
  task automatic t_decode();
    logic [7:0] v;
    logic [3:0] sh;
    wr(8'h20, 8'h04);
    chk({7'h0, ctrl.low_rate_mode}, 8'h01);
    wr(8'h3F, 8'h62);
    chk({4'h0, ctrl.ref_external, ctrl.chan_a_standby, ctrl.chan_b_standby, ctrl.ref_powered},
        8'h0F);
    wr(8'h3F, 8'h20);
    chk({5'h0, ctrl.ref_external, ctrl.chan_a_standby, ctrl.chan_b_standby}, 8'h00);
    for (int c = 8; c < 16; c++)
    begin
      wr(8'h40, 8'(c));
      pwr_bits(v);
      chk(v, pexp[c-8]);
    end
    wr(8'h40, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      power_pin_one   <= (p == 0);
      power_pin_two   <= 1'b1;
      power_pin_three <= (p == 1);
      repeat (3) @(posedge clk);
      pwr_bits(v);
      chk(v, p == 0 ? 8'h04 : 8'h18);
    end
    power_pin_two   <= 1'b0;
    power_pin_three <= 1'b0;
    for (int m = 0; m < 2; m++)
    begin
      wr(8'h41, {m[0], 7'h0});
      chk({7'h0, ctrl.ddr_output}, {7'h0, m[0]});
      foreach (pexp[c])
      begin
        wr(8'h44, {3'(c), 3'(c), 2'h0});
        sh = (c == 5) ? 4'h4 : (c == 6) ? 4'hA : (c == 7) ? 4'hC : 4'h0;
        chk({3'h0, ctrl.fall_edge}, {4'h0, sh});
        if (m == 1 && c == 6)
          chk({3'h0, ctrl.rise_edge}, 8'h10);
        else if (c == 0 || c >= 4)
          chk({3'h0, ctrl.rise_edge}, {4'h0, sh});
      end
    end
    wr(8'h40, 8'h0F);
    chk({7'h0, ctrl.channel_interleave_mode}, 8'h00);
  endtask
  task automatic t_pin_reset();
    wr(8'h68, 8'h50);
    reset_pulse <= 1'b1;
    @(posedge clk);
    reset_pulse <= 1'b0;
    repeat (3) @(posedge clk);
    chk({3'h0, ctrl.chan_b_coarse_gain, ctrl.ddr_output}, 8'h00);
  endtask

  initial
  begin
    clk             = 1'b0;
    sys_rst         = 1'b1;
    reset_pulse     = 1'b0;
    power_pin_one   = 1'b0;
    power_pin_two   = 1'b0;
    power_pin_three = 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    // ctrl takes its first decoded value one edge after release
    repeat (2) @(posedge clk);
    t_map();
    t_soft_reset();
    t_decode();
    t_pin_reset();
    test_done();
  end
  // full run is well under half a millisecond
  initial
  begin
    #3000000;
    n_errors++;
    test_done();
  end
endmodule // acr_config_regs_bench
